// [logic/incdec_consts.svh]
`ifndef INCDEC_CONSTS_SVH
`define INCDEC_CONSTS_SVH

// operand and datapath widths
`define FILE_ADDR_W 7
`define DATA_W 8
`define LIT_W 11
`define PC_W 13
`define LATCH_W 8

// upper target latch bits copied into the program counter top
`define LATCH_HI 4
`define LATCH_LO 3

// destination select encoding
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1

// arithmetic constants
`define ONE_VAL 8'h01
`define ZERO_VAL 8'h00

// instruction cycles used by a jump or a taken skip
`define LONG_OP_CYCLES 2

`endif

// [logic/incdec_pkg.sv]
package incdec_pkg;
  `include "incdec_consts.svh"

  // decoded operation presented by the instruction decoder
  typedef enum logic [2:0] {
    idle_op = 3'h0,
    invert_file_op = 3'h1,
    minus_one_op = 3'h2,
    plus_one_op = 3'h3,
    minus_one_skip_op = 3'h4,
    plus_one_skip_op = 3'h5,
    absolute_jump_op = 3'h6
  } op_t;

  // execution phase: normal issue, or the discarded second cycle
  typedef enum logic {
    run_st = 1'b0,
    discard_st = 1'b1
  } phase_t;

  // complete registered state of the execution block
  typedef struct packed {
    phase_t phase;
    logic file_we;
    logic acc_we;
    logic [`FILE_ADDR_W-1:0] waddr;
    logic [`DATA_W-1:0] result;
    logic z_we;
    logic z_val;
    logic pc_load;
    logic [`PC_W-1:0] pc;
    logic squash;
  } core_state_t;
endpackage

// [logic/incdec_alu.sv]
`timescale 1ns/10ps
`include "incdec_consts.svh"
module incdec_alu
  import incdec_pkg::*;
(
  // operation and operand
  input wire op_t op,
  input wire logic [`DATA_W-1:0] operand,
  // result and zero detect
  output logic [`DATA_W-1:0] result,
  output logic zero
);

  // zero detect shared by every operation
  function automatic logic is_zero(input logic [`DATA_W-1:0] v);
    return v == `ZERO_VAL;
  endfunction

  // 8-bit wrap-around increment and decrement, complement for invert_file_op, operand passed through otherwise
  always_comb begin
    result = operand;
    unique case (op)
      invert_file_op: result = ~operand;
      minus_one_op, minus_one_skip_op: result = operand - `ONE_VAL;
      plus_one_op, plus_one_skip_op: result = operand + `ONE_VAL;
      default: result = operand;
    endcase
    zero = is_zero(result);
  end

endmodule // incdec_alu

// [logic/incdec_exec.sv]
// Functional notes
// - complement addresses file register, updates zero flag
// - destination bit 0 accumulator, 1 file
// - jump loads literal into counter bits 10:0
// - jump copies latch bits 4:3, flags untouched
// - jump takes two cycles, discards fetched op
// - decrement to destination, updates zero flag
// - increment to destination, updates zero flag
// - decrement-skip writes destination, flags untouched
// - zero result replaces next op with idle
// - increment-skip likewise, no flags, zero skips
`timescale 1ns/10ps
`include "incdec_consts.svh"
module incdec_exec
  import incdec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // decoded instruction
  input wire logic op_valid,
  input wire op_t op,
  input wire logic [`FILE_ADDR_W-1:0] file_addr,
  input wire logic dest_sel,
  input wire logic [`LIT_W-1:0] literal,
  // operand and upper target latch
  input wire logic [`DATA_W-1:0] file_rdata,
  input wire logic [`LATCH_W-1:0] upper_target_latch,
  // issue handshake
  output logic ready,
  // file register and accumulator write
  output logic file_we,
  output logic [`FILE_ADDR_W-1:0] file_waddr,
  output logic acc_we,
  output logic [`DATA_W-1:0] result,
  // zero flag update
  output logic zero_we,
  output logic zero_val,
  // program counter load and fetch discard
  output logic pc_load,
  output logic [`PC_W-1:0] program_counter,
  output logic squash
);

  core_state_t s_q;
  core_state_t s_d;
  logic [`DATA_W-1:0] alu_res;
  logic alu_zero;
  logic take;

  // shared arithmetic and zero detect
  incdec_alu u_alu (
    .op(op),
    .operand(file_rdata),
    .result(alu_res),
    .zero(alu_zero)
  );

  // an instruction issues only in the normal phase
  assign ready = (s_q.phase == run_st);
  assign take = op_valid && ready;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.file_we = 1'b0;
    s_d.acc_we = 1'b0;
    s_d.z_we = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.squash = 1'b0;
    unique case (s_q.phase)
      run_st: begin
        if (op_valid) begin
          unique case (op)
            invert_file_op, minus_one_op, plus_one_op: begin
              s_d.file_we = (dest_sel == `DEST_FILE);
              s_d.acc_we = (dest_sel == `DEST_ACC);
              s_d.waddr = file_addr;
              s_d.result = alu_res;
              s_d.z_we = 1'b1;
              s_d.z_val = alu_zero;
            end
            minus_one_skip_op, plus_one_skip_op: begin
              s_d.file_we = (dest_sel == `DEST_FILE);
              s_d.acc_we = (dest_sel == `DEST_ACC);
              s_d.waddr = file_addr;
              s_d.result = alu_res;
              if (alu_zero) begin
                s_d.phase = discard_st;
                s_d.squash = 1'b1;
              end
            end
            absolute_jump_op: begin
              s_d.pc_load = 1'b1;
              s_d.pc = {upper_target_latch[`LATCH_HI:`LATCH_LO], literal};
              s_d.phase = discard_st;
              s_d.squash = 1'b1;
            end
            idle_op: begin
            end
            default: begin
            end
          endcase
        end
      end
      discard_st: s_d.phase = run_st;
      default: s_d.phase = run_st;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // registered outputs
  assign file_we = s_q.file_we;
  assign file_waddr = s_q.waddr;
  assign acc_we = s_q.acc_we;
  assign result = s_q.result;
  assign zero_we = s_q.z_we;
  assign zero_val = s_q.z_val;
  assign pc_load = s_q.pc_load;
  assign program_counter = s_q.pc;
  assign squash = s_q.squash;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_invert;
    take && op == invert_file_op |=> result == ~$past(file_rdata) && zero_we
      && zero_val == (~$past(file_rdata) == `ZERO_VAL);
  endproperty
  a_invert: assert property (p_invert) else $error("complement result wrong");

  property p_dest;
    take && op inside {invert_file_op, minus_one_op, plus_one_op, minus_one_skip_op,
      plus_one_skip_op} |=> file_we == $past(dest_sel) && acc_we == !$past(dest_sel)
      && file_waddr == $past(file_addr);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_jump_low;
    take && op == absolute_jump_op |=> pc_load
      && program_counter[`LIT_W-1:0] == $past(literal);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong");

  property p_jump_high;
    take && op == absolute_jump_op |=> !zero_we
      && program_counter[`PC_W-1:`LIT_W] == $past(upper_target_latch[`LATCH_HI:`LATCH_LO]);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("jump high bits wrong");

  property p_jump_two;
    take && op == absolute_jump_op |=> squash && !ready ##1 ready && !squash;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

  property p_dec;
    take && op == minus_one_op |=> zero_we && result == $past(file_rdata) - `ONE_VAL;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_inc;
    take && op == plus_one_op |=> zero_we && result == $past(file_rdata) + `ONE_VAL;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_dec_skip;
    take && op == minus_one_skip_op |=> !zero_we
      && result == $past(file_rdata) - `ONE_VAL;
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement-skip wrong");

  property p_skip_taken;
    take && op inside {minus_one_skip_op, plus_one_skip_op} |=>
      (result == `ZERO_VAL) == squash && ready == !squash;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("skip decision wrong");

  property p_inc_skip;
    take && op == plus_one_skip_op |=> !zero_we
      && result == $past(file_rdata) + `ONE_VAL;
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("increment-skip wrong");

  property p_wrap;
    take && op == plus_one_op && file_rdata == 8'hFF |=> result == `ZERO_VAL && zero_val;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment did not wrap");

  property p_single;
    take && op inside {invert_file_op, minus_one_op, plus_one_op} |=> ready && !squash;
  endproperty
  a_single: assert property (p_single) else $error("plain op not single cycle");

  property p_zero_flag;
    take && op inside {minus_one_op, plus_one_op} |=> zero_val == (result == `ZERO_VAL);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("inc/dec zero flag wrong");

  property p_wrap_dec;
    take && op == minus_one_op && file_rdata == `ZERO_VAL |=> result == 8'hFF && !zero_val;
  endproperty
  a_wrap_dec: assert property (p_wrap_dec) else $error("decrement did not wrap");

  property p_inc_skip_wrap;
    take && op == plus_one_skip_op && file_rdata == 8'hFF |=> result == `ZERO_VAL
      && squash;
  endproperty
  a_inc_skip_wrap: assert property (p_inc_skip_wrap) else $error("inc-skip wrap wrong");

  property p_idle;
    take && op == idle_op |=> !file_we && !acc_we && !zero_we && !pc_load && !squash
      && ready && $stable(result);
  endproperty
  a_idle: assert property (p_idle) else $error("idle op changed state");

  property p_refused;
    op_valid && !ready |=> !file_we && !acc_we && !zero_we && !pc_load && !squash
      && $stable(result);
  endproperty
  a_refused: assert property (p_refused) else $error("op in discard cycle acted");

  // covers for the main scenarios
  c_jump: cover property (take && op == absolute_jump_op ##2 ready);
  c_skip: cover property (take && op == minus_one_skip_op ##1 squash);
  c_noskip: cover property (take && op == plus_one_skip_op ##1 !squash);
  c_wrap_dec: cover property (take && op == minus_one_op && file_rdata == `ZERO_VAL);
  c_refused: cover property (op_valid && !ready);

endmodule // incdec_exec

// [tb/testbench.sv]
`timescale 1ns/10ps
`include "incdec_consts.svh"
module testbench
  import incdec_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  op_t op = idle_op;
  logic [`FILE_ADDR_W-1:0] file_addr = 7'h00;
  logic dest_sel = 1'b0;
  logic [`LIT_W-1:0] literal = 11'h000;
  logic [`DATA_W-1:0] file_rdata = 8'h00;
  logic [`LATCH_W-1:0] upper_target_latch = 8'h00;
  logic ready, file_we, acc_we, zero_we, zero_val, pc_load, squash;
  logic [`FILE_ADDR_W-1:0] file_waddr;
  logic [`DATA_W-1:0] result;
  logic [`PC_W-1:0] program_counter;
  int miscompares = 0;
  int tests_run = 0;
  logic [`DATA_W-1:0] last_res = 8'h00;

  // 40 MHz instruction clock
  always #12.5 clk = ~clk;

  incdec_exec i_incdec_exec (.clk(clk), .reset(reset), .op_valid(op_valid), .op(op),
    .file_addr(file_addr), .dest_sel(dest_sel), .literal(literal), .file_rdata(file_rdata),
    .upper_target_latch(upper_target_latch), .ready(ready), .file_we(file_we),
    .file_waddr(file_waddr), .acc_we(acc_we), .result(result), .zero_we(zero_we),
    .zero_val(zero_val), .pc_load(pc_load), .program_counter(program_counter),
    .squash(squash));

  // prints the verdict and ends the run
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compares one result value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // issues one op at a falling edge, checks outputs one cycle later
  // strobes: file_we, acc_we, zero_we, pc_load, squash, ready
  task automatic exec(input op_t o, input logic [6:0] a, input logic d, input logic [7:0] rd,
      input logic [10:0] k, input logic [7:0] lat, input logic [7:0] er, input logic [5:0] st);
    op_valid = 1'b1;
    op = o;
    file_addr = a;
    dest_sel = d;
    file_rdata = rd;
    literal = k;
    upper_target_latch = lat;
    @(posedge clk);
    @(negedge clk);
    chk({2'h0, result, file_we, acc_we, zero_we, pc_load, squash, ready}, {2'h0, er, st});
    if (st[5]) begin
      chk({9'h000, file_waddr}, {9'h000, a});
    end
    last_res = er;
  endtask

  // complement, decrement, increment to both destinations, wrap values
  task automatic t_plain();
    logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};
    logic [7:0] er;
    op_t o;
    for (int d = 0; d < 2; d++) begin
      foreach (vals[i]) begin
        for (int n = 0; n < 3; n++) begin
          o = (n == 0) ? invert_file_op : (n == 1) ? minus_one_op : plus_one_op;
          er = (n == 0) ? ~vals[i] : (n == 1) ? vals[i] - 8'h01 : vals[i] + 8'h01;
          exec(o, vals[i][6:0], d[0], vals[i], 11'h000, 8'h00, er,
            {d[0], ~d[0], 4'b1001});
          chk({15'h0000, zero_val}, {15'h0000, er == 8'h00});
        end
      end
    end
  endtask

  // skips taken and untaken, op offered in the discard cycle is refused
  task automatic t_skip();
    op_t o;
    for (int s = 0; s < 2; s++) begin
      o = s ? plus_one_skip_op : minus_one_skip_op;
      for (int d = 0; d < 2; d++) begin
        exec(o, 7'h7F, d[0], s ? 8'hFF : 8'h01, 11'h000, 8'h00, 8'h00,
          {d[0], ~d[0], 4'b0010});
        exec(plus_one_op, 7'h05, 1'b1, 8'h33, 11'h000, 8'h00, 8'h00, 6'b000001);
        exec(o, 7'h00, d[0], s ? 8'h7F : 8'h03, 11'h000, 8'h00, s ? 8'h80 : 8'h02,
          {d[0], ~d[0], 4'b0001});
      end
    end
  endtask

  // jumps with boundary literals and latch patterns
  task automatic t_jump();
    exec(absolute_jump_op, 7'h00, 1'b0, 8'h00, 11'h7FF, 8'hF7, last_res, 6'b000110);
    chk({3'h0, program_counter}, 16'h17FF);
    exec(minus_one_op, 7'h01, 1'b0, 8'h10, 11'h000, 8'h00, last_res, 6'b000001);
    exec(absolute_jump_op, 7'h00, 1'b0, 8'h00, 11'h000, 8'h08, last_res, 6'b000110);
    chk({3'h0, program_counter}, 16'h0800);
    exec(idle_op, 7'h00, 1'b0, 8'h00, 11'h000, 8'h00, last_res, 6'b000001);
    exec(plus_one_op, 7'h02, 1'b0, 8'h41, 11'h000, 8'h00, 8'h42, 6'b011001);
    exec(idle_op, 7'h03, 1'b1, 8'h55, 11'h000, 8'h00, 8'h42, 6'b000001);
  endtask

  // watchdog against a stalled run
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    chk({2'h0, result, file_we, acc_we, zero_we, pc_load, squash, ready}, 16'h0001);
    t_plain();
    t_skip();
    t_jump();
    op_valid = 1'b0;
    repeat (2) @(negedge clk);
    complete_run();
  end
endmodule // testbench
